// file: src/tgsc_regs.vh
`ifndef TGSC_REGS_VH
`define TGSC_REGS_VH

// Register byte offsets
`define TGSC_CTRL_OFS 8'h00
`define TGSC_STATUS_OFS 8'h04
`define TGSC_LIM0_OFS 8'h08
`define TGSC_AUTO_UP_OFS 8'h18
`define TGSC_AUTO_DN_OFS 8'h1c
`define TGSC_KD_LIM_OFS 8'h20

// Field positions
`define TGSC_CTRL_AUTO_BIT 0
`define TGSC_LIM_LO_LSB 0
`define TGSC_LIM_HI_LSB 16
`define TGSC_ST_GEAR_LSB 0
`define TGSC_ST_FWD_BIT 3
`define TGSC_ST_BWD_BIT 4
`define TGSC_ST_KD_BIT 5
`define TGSC_ST_MISM_BIT 6
`define TGSC_ST_FAULT_BIT 7
`define TGSC_ST_SPEED_LSB 16

// Reset values (speed in sensor pulses per gate window)
`define TGSC_CTRL_RST 32'h0000_0000
`define TGSC_LIM1_RST 32'h0040_0000
`define TGSC_LIM2_RST 32'h0080_0000
`define TGSC_LIM3_RST 32'h0100_0020
`define TGSC_LIM4_RST 32'hffff_0040
`define TGSC_AUTO_UP_RST 32'h0060_0030
`define TGSC_AUTO_DN_RST 32'h0050_0020
`define TGSC_KD_LIM_RST 32'h0000_0038

// Timing
`define TGSC_CLK_KHZ 50000
`define TGSC_GATE_MS 100
`define TGSC_BLINK_MS 250
`define TGSC_GATE_CYC (`TGSC_GATE_MS * `TGSC_CLK_KHZ)
`define TGSC_BLINK_CYC (`TGSC_BLINK_MS * `TGSC_CLK_KHZ)

`endif

// file: src/tgsc_speed.v
`default_nettype none
module tgsc_speed #(
  parameter GATE_CYCLES = 5000000
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Synchronised sensor pulse train
  input wire pulse_i,
  // Pulses counted in the last complete gate window
  output reg [15:0] speed_o
);
  reg [31:0] gate_q;
  reg [15:0] cnt_q;
  reg pulse_q;
  wire rise = pulse_i & ~pulse_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_q <= 32'h0000_0000;
      cnt_q <= 16'h0000;
      pulse_q <= 1'b0;
      speed_o <= 16'h0000;
    end else begin
      pulse_q <= pulse_i;
      if (gate_q == GATE_CYCLES - 1) begin
        gate_q <= 32'h0000_0000;
        speed_o <= cnt_q;
        cnt_q <= {15'h0000, rise};
      end else begin
        gate_q <= gate_q + 32'h0000_0001;
        // Saturate rather than wrap so an overspeed never reads as slow
        if (rise && cnt_q != 16'hffff)
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // tgsc_speed
`default_nettype wire

// file: src/tgsc_sync.v
`default_nettype none
module tgsc_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Asynchronous levels in, synchronised levels out
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // tgsc_sync
`default_nettype wire

// file: src/tgsc_top.v
`include "tgsc_regs.vh"
`default_nettype none
module tgsc_top #(
  parameter GATE_CYCLES = `TGSC_GATE_CYC,
  parameter BLINK_CYCLES = `TGSC_BLINK_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Driver inputs (pins)
  input wire forward_direction_sel_i,
  input wire backward_direction_sel_i,
  input wire [1:0] gear_sel_i,
  input wire declutch_i,
  input wire kickdown_i,
  input wire four_wheel_drive_sw_i,
  input wire differential_lock_sw_i,
  input wire brake_i,
  input wire speed_pulse_i,
  // Valve and lamp outputs
  output reg forward_direction_valve_o,
  output reg backward_direction_valve_o,
  output reg [3:0] gear_valve_o,
  output reg four_wheel_drive_valve_o,
  output reg differential_lock_valve_o,
  output reg status_lamp_o
);
  localparam [2:0] GEAR_NONE = 3'd0;
  localparam [2:0] GEAR_1 = 3'd1;
  localparam [2:0] GEAR_2 = 3'd2;
  localparam [2:0] GEAR_3 = 3'd3;
  localparam [2:0] GEAR_4 = 3'd4;
  localparam [1:0] POS_4 = 2'd3;

  // Gear group tests shared by the drive and lock logic
  function is_low_gear;
    input [2:0] g;
    begin
      is_low_gear = (g == GEAR_1) || (g == GEAR_2);
    end
  endfunction

  function is_high_gear;
    input [2:0] g;
    begin
      is_high_gear = (g == GEAR_3) || (g == GEAR_4);
    end
  endfunction

  // Speed window test on a limit word: low half is minimum, high half maximum
  function in_window;
    input [15:0] spd;
    input [31:0] lim;
    begin
      in_window = (spd >= lim[`TGSC_LIM_HI_LSB-1:`TGSC_LIM_LO_LSB]) &&
                  (spd <= lim[31:`TGSC_LIM_HI_LSB]);
    end
  endfunction

  // Byte-lane merge of a write into a register word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          merge[b*8 +: 8] = wdat[b*8 +: 8];
    end
  endfunction

  // Pin synchronisers: pins move at any moment, so nothing reads them
  // before both flops
  wire [9:0] pins_s;
  tgsc_sync #(.W(10)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({speed_pulse_i, brake_i, differential_lock_sw_i, four_wheel_drive_sw_i,
          kickdown_i, declutch_i, gear_sel_i, backward_direction_sel_i,
          forward_direction_sel_i}),
    .q_o(pins_s)
  );
  wire fwd_s = pins_s[0];
  wire bwd_s = pins_s[1];
  wire [1:0] pos_s = pins_s[3:2];
  wire declutch_s = pins_s[4];
  wire kd_s = pins_s[5];
  wire fwd_drive_sw_s = pins_s[6];
  wire lock_sw_s = pins_s[7];
  wire brake_s = pins_s[8];

  wire [15:0] speed;
  tgsc_speed #(.GATE_CYCLES(GATE_CYCLES)) u_speed (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pulse_i(pins_s[9]),
    .speed_o(speed)
  );

  // Registers
  reg [31:0] ctrl_q;
  reg [31:0] lim_q [0:3];
  reg [31:0] auto_up_q;
  reg [31:0] auto_dn_q;
  reg [31:0] kd_lim_q;

  // Block state
  reg [2:0] engaged_q;
  reg [2:0] auto_gear_q;
  reg auto_run_q;
  reg kd_q;
  reg kd_prev_q;
  reg [1:0] pos_prev_q;
  reg [31:0] blink_cnt_q;
  reg blink_q;

  wire auto_mode = ctrl_q[`TGSC_CTRL_AUTO_BIT];
  wire sel_fault = fwd_s & bwd_s;
  wire pos_moved = (pos_s != pos_prev_q);
  wire kd_press = kd_s & ~kd_prev_q;
  wire auto_pos = auto_mode && (pos_s == POS_4);
  wire [15:0] kd_limit = kd_lim_q[15:0];

  // Requested gear
  reg [2:0] target;
  always @* begin
    if (kd_q)
      target = GEAR_1;
    else if (auto_pos)
      target = auto_gear_q;
    else
      target = {1'b0, pos_s} + 3'd1;
  end

  // Window test for every gear; the requested gear picks one below
  wire [3:0] win_ok;
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw = gw + 1) begin : g_window
      assign win_ok[gw] = in_window(speed, lim_q[gw]);
    end
  endgenerate
  wire [1:0] target_idx = target[1:0] - 2'd1;
  // Manual kick-down bypasses the speed window
  wire kd_hold = kd_q && !auto_pos;
  wire gate_ok = kd_hold || win_ok[target_idx];
  wire mismatch = (engaged_q != target);

  // Wishbone slave: one wait state, ack drops the cycle after it is given
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  integer i;
  integer j;

  // Status word, assembled field by field; unused bits read as zero
  reg [31:0] status_word;
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`TGSC_ST_GEAR_LSB +: 3] = engaged_q;
    status_word[`TGSC_ST_FWD_BIT] = forward_direction_valve_o;
    status_word[`TGSC_ST_BWD_BIT] = backward_direction_valve_o;
    status_word[`TGSC_ST_KD_BIT] = kd_q;
    status_word[`TGSC_ST_MISM_BIT] = mismatch;
    status_word[`TGSC_ST_FAULT_BIT] = sel_fault;
    status_word[`TGSC_ST_SPEED_LSB +: 16] = speed;
  end

  // Read multiplexer; unmapped offsets read as zero
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    j = 0;
    case (wb_adr_i)
      `TGSC_CTRL_OFS: rd_word = ctrl_q;
      `TGSC_STATUS_OFS: rd_word = status_word;
      `TGSC_AUTO_UP_OFS: rd_word = auto_up_q;
      `TGSC_AUTO_DN_OFS: rd_word = auto_dn_q;
      `TGSC_KD_LIM_OFS: rd_word = kd_lim_q;
      default: begin
        for (j = 0; j < 4; j = j + 1)
          if (wb_adr_i == `TGSC_LIM0_OFS + 4 * j)
            rd_word = lim_q[j];
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q <= `TGSC_CTRL_RST;
      lim_q[0] <= `TGSC_LIM1_RST;
      lim_q[1] <= `TGSC_LIM2_RST;
      lim_q[2] <= `TGSC_LIM3_RST;
      lim_q[3] <= `TGSC_LIM4_RST;
      auto_up_q <= `TGSC_AUTO_UP_RST;
      auto_dn_q <= `TGSC_AUTO_DN_RST;
      kd_lim_q <= `TGSC_KD_LIM_RST;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i)
        wb_dat_o <= rd_word;
      if (wb_wr) begin
        case (wb_adr_i)
          `TGSC_CTRL_OFS: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0001;
          `TGSC_AUTO_UP_OFS: auto_up_q <= merge(auto_up_q, wb_dat_i, wb_sel_i);
          `TGSC_AUTO_DN_OFS: auto_dn_q <= merge(auto_dn_q, wb_dat_i, wb_sel_i);
          `TGSC_KD_LIM_OFS: kd_lim_q <= merge(kd_lim_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
          default: begin
            for (i = 0; i < 4; i = i + 1)
              if (wb_adr_i == `TGSC_LIM0_OFS + 4 * i)
                lim_q[i] <= merge(lim_q[i], wb_dat_i, wb_sel_i);
          end
        endcase
      end
    end
  end

  // Kick-down: arms in second, toggles back to second from first
  // A selector move in the cycle of a press wins, so a stale press never arms
  always @(posedge clk_i) begin
    if (rst_i) begin
      kd_q <= 1'b0;
      kd_prev_q <= 1'b0;
      pos_prev_q <= 2'd0;
    end else begin
      kd_prev_q <= kd_s;
      pos_prev_q <= pos_s;
      // Direction inputs are not looked at here on purpose
      if (pos_moved)
        kd_q <= 1'b0;
      else if (auto_pos && speed > kd_limit)
        kd_q <= 1'b0;
      else if (kd_press) begin
        if (!kd_q && engaged_q == GEAR_2)
          kd_q <= 1'b1;
        else if (kd_q && engaged_q == GEAR_1)
          kd_q <= 1'b0;
      end
    end
  end

  // Automatic shifting between second and fourth with hysteresis
  // Shifts wait until the last one has landed, so the windows cannot race
  always @(posedge clk_i) begin
    if (rst_i) begin
      auto_gear_q <= GEAR_2;
      auto_run_q <= 1'b0;
    end else begin
      auto_run_q <= auto_pos;
      if (!auto_pos || !auto_run_q)
        auto_gear_q <= GEAR_2;
      else if (engaged_q == auto_gear_q && !kd_q) begin
        case (auto_gear_q)
          GEAR_2: if (speed > auto_up_q[15:0]) auto_gear_q <= GEAR_3;
          GEAR_3: begin
            if (speed > auto_up_q[31:16])
              auto_gear_q <= GEAR_4;
            else if (speed < auto_dn_q[15:0])
              auto_gear_q <= GEAR_2;
          end
          GEAR_4: if (speed < auto_dn_q[31:16]) auto_gear_q <= GEAR_3;
          default: auto_gear_q <= GEAR_2;
        endcase
      end
    end
  end

  // Engaged gear follows the request only through the speed gate
  reg [2:0] engaged_d;
  always @* begin
    engaged_d = engaged_q;
    if (mismatch && gate_ok)
      engaged_d = target;
  end

  always @(posedge clk_i) begin
    if (rst_i)
      engaged_q <= GEAR_NONE;
    else
      engaged_q <= engaged_d;
  end

  // Status lamp: blinking for a selector fault, steady for a gear mismatch
  // Blink counter runs freely; the lamp phase at the start of a fault is arbitrary
  always @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_CYCLES - 1) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // One-hot gear valve pattern: bit n stands for gear n+1
  wire [3:0] gear_onehot;
  genvar gd;
  generate
    for (gd = 0; gd < 4; gd = gd + 1) begin : g_gear_dec
      assign gear_onehot[gd] = ({29'h0000_0000, engaged_q} == gd + 1);
    end
  endgenerate

  // Valve drivers
  always @(posedge clk_i) begin
    if (rst_i) begin
      forward_direction_valve_o <= 1'b0;
      backward_direction_valve_o <= 1'b0;
      gear_valve_o <= 4'h0;
      four_wheel_drive_valve_o <= 1'b1;
      differential_lock_valve_o <= 1'b0;
      status_lamp_o <= 1'b0;
    end else begin
      // Both direction inputs together count as neutral, never as a drive
      forward_direction_valve_o <= fwd_s & ~bwd_s & ~declutch_s;
      backward_direction_valve_o <= bwd_s & ~fwd_s & ~declutch_s;
      // Gear valves hold through a declutch, so release needs no new gate pass
      gear_valve_o <= gear_onehot;
      // Drive valve energised means four-wheel drive is off; lock valve energised means the lock is on
      four_wheel_drive_valve_o <= ~(fwd_drive_sw_s | (brake_s & is_high_gear(engaged_q)));
      differential_lock_valve_o <= lock_sw_s & is_low_gear(engaged_q);
      status_lamp_o <= sel_fault ? blink_q : mismatch;
    end
  end
endmodule // tgsc_top
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, kickdown_i, brake_i;
  logic [7:0] wb_adr_i, period;
  logic [3:0] wb_sel_i, gear_valve_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0] gear_sel_i;
  logic forward_direction_sel_i, backward_direction_sel_i, declutch_i, speed_pulse_i;
  logic four_wheel_drive_sw_i, differential_lock_sw_i, status_lamp_o;
  logic forward_direction_valve_o, backward_direction_valve_o, four_wheel_drive_valve_o;
  logic differential_lock_valve_o;
  logic [8:0] obs;
  int n_mismatch, checks_done;
  assign obs = {status_lamp_o, differential_lock_valve_o, four_wheel_drive_valve_o,
    gear_valve_o, backward_direction_valve_o, forward_direction_valve_o};
  tgsc_top #(.GATE_CYCLES(400), .BLINK_CYCLES(8)) uut (.*);
  tgsc_vehicle veh (.clk_i(clk_i), .period_i(period), .pulse_o(speed_pulse_i));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic see(input logic [8:0] exp, input logic [8:0] m);
    int i;
    for (i = 0; i < 3000 && (obs & m) !== exp; i++) @(posedge clk_i);
    cmp({23'h0, obs & m}, {23'h0, exp});
  endtask
  // On reads d is the expected word
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    if (!we) cmp(wb_dat_o, d);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] d, input logic [1:0] g);
    @(posedge clk_i);
    forward_direction_sel_i <= d[0];
    backward_direction_sel_i <= d[1];
    gear_sel_i <= g;
  endtask
  // Press long enough to pass the synchronisers
  task automatic kd;
    @(posedge clk_i);
    kickdown_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    kickdown_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  function automatic logic [8:0] gv(input int g);
    return 9'h004 << (g - 1);
  endfunction
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    #1000000;
    n_mismatch++;
    conclude;
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, kickdown_i, brake_i, declutch_i} = '0;
    {forward_direction_sel_i, backward_direction_sel_i, four_wheel_drive_sw_i} = '0;
    {differential_lock_sw_i, gear_sel_i, wb_adr_i, wb_dat_i, period} = '0;
    wb_sel_i = 4'hf;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp({23'h0, obs}, 32'h0000_0040);
    wb(1'b0, 8'h00, 32'h0000_0000);
    wb(1'b0, 8'h08, 32'h0040_0000);
    wb(1'b0, 8'h20, 32'h0000_0038);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0000_0000);
    // Third gear usable at standstill so the gear loop needs no speed
    wb(1'b1, 8'h10, 32'h0100_0000);
    see(gv(1), 9'h03f);
    for (int d = 1; d < 3; d++) begin
      for (int g = 1; g < 4; g++) begin
        pins(d[1:0], 2'(g - 1));
        see(gv(g) | 9'(d), 9'h03f);
      end
    end
    pins(2'd3, 2'd3);
    see(9'h100, 9'h103);
    see(9'h000, 9'h103);
    pins(2'd1, 2'd3);
    repeat (20) @(posedge clk_i);
    see(9'h101 | gv(3), 9'h13f);
    period <= 8'd4;
    see(9'h001 | gv(4), 9'h13f);
    brake_i <= 1'b1;
    see(9'h000, 9'h040);
    brake_i <= 1'b0;
    differential_lock_sw_i <= 1'b1;
    see(9'h040, 9'h0c0);
    four_wheel_drive_sw_i <= 1'b1;
    see(9'h000, 9'h040);
    four_wheel_drive_sw_i <= 1'b0;
    declutch_i <= 1'b1;
    see(gv(4), 9'h03f);
    declutch_i <= 1'b0;
    see(9'h001 | gv(4), 9'h03f);
    pins(2'd1, 2'd1);
    see(9'h081 | gv(2), 9'h0bf);
    kd;
    see(9'h081 | gv(1), 9'h0bf);
    pins(2'd2, 2'd1);
    // Give a wrongly cancelled kick-down time to show in the gear valves
    repeat (20) @(posedge clk_i);
    see(9'h002 | gv(1), 9'h03f);
    kd;
    see(9'h002 | gv(2), 9'h03f);
    kd;
    see(9'h002 | gv(1), 9'h03f);
    pins(2'd2, 2'd2);
    see(9'h002 | gv(3), 9'h03f);
    kd;
    see(9'h002 | gv(3), 9'h03f);
    period <= 8'd0;
    // Let two gate windows end, the second reporting standstill
    repeat (900) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'hffff_ffff);
    wb(1'b0, 8'h00, 32'h0000_0001);
    pins(2'd2, 2'd3);
    see(9'h002 | gv(2), 9'h13f);
    kd;
    see(9'h002 | gv(1), 9'h03f);
    period <= 8'd4;
    see(9'h002 | gv(4), 9'h03f);
    period <= 8'd0;
    see(9'h002 | gv(2), 9'h03f);
    wb(1'b1, 8'h00, 32'h0000_0000);
    see(9'h100, 9'h100);
    conclude;
  end
endmodule // testbench
`default_nettype wire

// file: testbench/tgsc_top_monitor.sv
`default_nettype none
module tgsc_top_monitor (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic forward_direction_sel_i,
  input wire logic backward_direction_sel_i,
  input wire logic declutch_i,
  input wire logic four_wheel_drive_sw_i,
  input wire logic differential_lock_sw_i,
  input wire logic brake_i,
  // Valves
  input wire logic forward_direction_valve_o,
  input wire logic backward_direction_valve_o,
  input wire logic [3:0] gear_valve_o,
  input wire logic four_wheel_drive_valve_o,
  input wire logic differential_lock_valve_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [1:0] dirv = {backward_direction_valve_o, forward_direction_valve_o};
  wire logic hi_gear = |gear_valve_o[3:2];
  wire logic lo_gear = |gear_valve_o[1:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Two sync flops plus the output flop: four samples cover the pin lag
  sequence dir_run(f, b);
    (!rst_i && forward_direction_sel_i == f && backward_direction_sel_i == b && !declutch_i)[*4];
  endsequence
  sequence clutch_held;
    (!rst_i && declutch_i)[*4];
  endsequence
  a_neutral_off: assert property (dir_run(1'b0, 1'b0) |-> dirv == 2'b00)
    else $error("direction valve on in neutral");
  a_forward_on: assert property (dir_run(1'b1, 1'b0) |-> dirv == 2'b01)
    else $error("forward valve wrong");
  a_backward_on: assert property (dir_run(1'b0, 1'b1) |-> dirv == 2'b10)
    else $error("backward valve wrong");
  a_declutch_cut: assert property (clutch_held |-> dirv == 2'b00)
    else $error("declutch left a direction on");
  a_gear_single: assert property ($onehot0(gear_valve_o))
    else $error("more than one gear valve on");
  a_brake_drive: assert property ((!rst_i && brake_i && hi_gear)[*4] |->
    !four_wheel_drive_valve_o) else $error("braking in high gear kept drive off");
  a_switch_drive: assert property ((!rst_i && four_wheel_drive_sw_i && |gear_valve_o)[*4] |->
    !four_wheel_drive_valve_o) else $error("switch did not engage drive");
  a_drive_inverted: assert property ((!rst_i && !four_wheel_drive_sw_i && !brake_i)[*4] |->
    four_wheel_drive_valve_o) else $error("drive valve not energised when off");
  a_lock_low_gear: assert property ((!rst_i && differential_lock_sw_i && lo_gear)[*4] |->
    differential_lock_valve_o) else $error("lock valve off in low gear");
  a_lock_high_off: assert property ((!rst_i && hi_gear)[*3] |-> !differential_lock_valve_o)
    else $error("lock valve on in high gear");
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("bus answer not a single pulse");
endmodule // tgsc_top_monitor
bind tgsc_top tgsc_top_monitor u_mon (.*);
`default_nettype wire

// file: testbench/tgsc_vehicle.sv
`default_nettype none
module tgsc_vehicle (
  // Clock
  input wire logic clk_i,
  // Cycles between sensor pulses, zero keeps the wheel still
  input wire logic [7:0] period_i,
  // Speed sensor pulse train
  output wire logic pulse_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q = 8'h00;
  logic pulse_q = 1'b0;
  assign pulse_o = pulse_q;
  always @(posedge clk_i) begin
    cnt_q <= (cnt_q + 8'h01 >= period_i) ? 8'h00 : cnt_q + 8'h01;
    pulse_q <= period_i != 8'h00 && cnt_q == 8'h00;
  end
endmodule // tgsc_vehicle
`default_nettype wire
